// ---- design/vbs_map.svh ----
// constants of the video bus status register bank
// Function
// - misc output register is write only and keeps only bits 0, 2, 3, 4
// - reads the device does not own pass the local data bus through
// - misc bit 0 resets low and moves crt registers from 3Bx to 3Dx
// - misc bits 2 and 3 reset low and drive the clock choice pins
// - misc bit 4 resets low and drives the own video select pin
// - status zero is read only; controller gives bit 7, device the rest
// - status zero read during emulation passes the local data bus through
// - status zero bit 4 returns the live switch sense pin
// - status zero bits 5 and 6 return feature code pins 0 and 1
// - status one address follows mode and address select bit
// - native status one: device bits 1-2, controller 0,3-5, bits 6-7 high
// - colour status one: controller bit 0, device bits 1-3, bits 4-7 high
// - mono status one: device bits 0, 3, 7; other bits read high
// - bit 0 is display enable, or horizontal pin level in mono mode
// - status bit 1 reports the light pen latch, or reads high in mono mode
// - status bit 2 reports the light pen switch input, or reads high in mono mode
// - bit 3: controller retrace, inverted vertical pin, or mono status pin
// - status bit 7 follows the vertical pin in mono mode and reads high otherwise
// - emulation select bits choose status layout and light pen addresses
// - light pen latch set by software or pen pulse; software clears it
`ifndef VBS_MAP_SVH
`define VBS_MAP_SVH
`define VBS_A_MISC      10'h3C2
`define VBS_A_STAT0     10'h3C2
`define VBS_A_STAT1_B   10'h3BA
`define VBS_A_STAT1_D   10'h3DA
`define VBS_A_IDX_B     10'h3B4
`define VBS_A_IDX_D     10'h3D4
`define VBS_A_DAT_B     10'h3B5
`define VBS_A_DAT_D     10'h3D5
`define VBS_A_PSET_D    10'h3DC
`define VBS_A_PCLR_D    10'h3DB
`define VBS_A_PSET_B    10'h3B9
`define VBS_A_PCLR_B    10'h3BB
`define VBS_EMU_INDEX   8'hFF
`define VBS_B_ADDR_SEL  0
`define VBS_B_CLK0      2
`define VBS_B_CLK1      3
`define VBS_B_VIDEO     4
`define VBS_B_COLOUR_EN 0
`define VBS_B_MONO_EN   1
`define VBS_B_EMU_RUN   2
`define VBS_RST_MISC    4'h0
`define VBS_RST_EMU     3'h0
`define VBS_RST_INDEX   8'h00
`endif

// ---- design/vbs_pkg.sv ----
// types of the video bus status register bank
package vbs_pkg;
  typedef enum logic [1:0] {VBS_NATIVE, VBS_COLOUR, VBS_MONO} vbs_mode_type;
  typedef struct packed {
    logic       own_video;
    logic [1:0] clk_sel;
    logic       addr_sel;
  } vbs_misc_type;
  typedef struct packed {
    logic emu_run;
    logic mono_en;
    logic colour_en;
  } vbs_emu_type;
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] data;
  } vbs_host_type;
endpackage : vbs_pkg

// ---- design/vbs_status_regs.sv ----
// register and status logic of the video bus interface companion
`timescale 1ns/10ps
`default_nettype none
`include "vbs_map.svh"
module vbs_status_regs #(
  parameter int NPIN = 10
) (
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire vbs_pkg::vbs_host_type host_i,
  input  wire logic              host_rd_n_i,
  input  wire logic              host_wr_n_i,
  output logic [7:0]             host_data_o,
  output logic                   host_data_oe_n_o,
  input  wire logic [7:0]        local_data_i,
  input  wire logic              switch_sense_i,
  input  wire logic              feature_code_in_0_i,
  input  wire logic              feature_code_in_1_i,
  input  wire logic              horizontal_level_in_i,
  input  wire logic              vertical_level_in_i,
  input  wire logic              mono_status_in_i,
  input  wire logic              pen_pulse_in_n_i,
  input  wire logic              pen_switch_i,
  output logic                   clock_choice_out_0_o,
  output logic                   clock_choice_out_1_o,
  output logic                   own_video_select_out_o
);
  import vbs_pkg::*;

  localparam int P_RD = 0, P_WR = 1, P_SW = 2, P_F0 = 3, P_F1 = 4;
  localparam int P_H = 5, P_V = 6, P_MS = 7, P_PEN = 8, P_PSW = 9;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] s1_r, s2_r, s3_r, stab_r;
  logic [NPIN-1:0] s1_nxt, s2_nxt, s3_nxt, stab_nxt;

  assign pin_raw = {pen_switch_i, pen_pulse_in_n_i, mono_status_in_i, vertical_level_in_i,
                    horizontal_level_in_i, feature_code_in_1_i, feature_code_in_0_i,
                    switch_sense_i, host_wr_n_i, host_rd_n_i};

  // a level counts once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      always_comb begin
        s1_nxt[g]   = pin_raw[g];
        s2_nxt[g]   = s1_r[g];
        s3_nxt[g]   = s2_r[g];
        stab_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : stab_r[g];
      end
    end
  endgenerate

  // strobes and pulse idle high
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_r   <= '1;
      s2_r   <= '1;
      s3_r   <= '1;
      stab_r <= '1;
    end else begin
      s1_r   <= s1_nxt;
      s2_r   <= s2_nxt;
      s3_r   <= s3_nxt;
      stab_r <= stab_nxt;
    end
  end

  // ----------------------------------------
  // decode
  // ----------------------------------------
  vbs_misc_type misc_r, misc_nxt;
  vbs_emu_type  emu_r, emu_nxt;
  logic [7:0]   index_r, index_nxt;
  logic         pen_r, pen_nxt;
  logic         rd_prev_r, wr_prev_r, pen_prev_r;
  vbs_mode_type mode;
  logic         rd_act, rd_edge, wr_edge, pen_fall;
  logic         pen_set, pen_clr;
  logic [9:0]   a;

  // status one address for a mode
  function automatic logic stat1_hit(input logic [9:0] ad, input vbs_mode_type m,
                                     input logic sel);
    stat1_hit = 1'b0;
    unique case (m)
      VBS_COLOUR: stat1_hit = (ad == `VBS_A_STAT1_D);
      VBS_MONO:   stat1_hit = (ad == `VBS_A_STAT1_B);
      VBS_NATIVE: stat1_hit = (ad == (sel ? `VBS_A_STAT1_D : `VBS_A_STAT1_B));
    endcase
  endfunction : stat1_hit

  // crt index or data address under the select bit
  function automatic logic crt_hit(input logic [9:0] ad, input logic sel,
                                   input logic [9:0] b, input logic [9:0] d);
    crt_hit = (ad == (sel ? d : b));
  endfunction : crt_hit

  // mode from emulation select bits
  always_comb begin
    mode = VBS_NATIVE;
    if (emu_r.emu_run && emu_r.colour_en)
      mode = VBS_COLOUR;
    else if (emu_r.emu_run && emu_r.mono_en)
      mode = VBS_MONO;
  end

  assign a        = host_i.addr;
  assign rd_act   = !stab_r[P_RD];
  assign rd_edge  = rd_act && rd_prev_r;
  assign wr_edge  = !stab_r[P_WR] && wr_prev_r;
  assign pen_fall = !stab_r[P_PEN] && pen_prev_r;

  // light pen software strobes per mode
  always_comb begin
    pen_set = 1'b0;
    pen_clr = 1'b0;
    unique case (mode)
      VBS_NATIVE: begin
        pen_set = wr_edge && (a == `VBS_A_PSET_D);
        pen_clr = wr_edge && (a == `VBS_A_PCLR_D);
      end
      VBS_COLOUR: begin
        pen_set = (wr_edge || rd_edge) && (a == `VBS_A_PSET_D);
        pen_clr = (wr_edge || rd_edge) && (a == `VBS_A_PCLR_D);
      end
      VBS_MONO: begin
        pen_set = wr_edge && (a == `VBS_A_PSET_B);
        pen_clr = wr_edge && (a == `VBS_A_PCLR_B);
      end
    endcase
  end

  // ----------------------------------------
  // write registers and light pen latch
  // ----------------------------------------
  always_comb begin
    misc_nxt  = misc_r;
    emu_nxt   = emu_r;
    index_nxt = index_r;
    if (wr_edge && a == `VBS_A_MISC) begin
      misc_nxt.addr_sel  = host_i.data[`VBS_B_ADDR_SEL];
      misc_nxt.clk_sel   = {host_i.data[`VBS_B_CLK1], host_i.data[`VBS_B_CLK0]};
      misc_nxt.own_video = host_i.data[`VBS_B_VIDEO];
    end
    if (wr_edge && crt_hit(a, misc_r.addr_sel, `VBS_A_IDX_B, `VBS_A_IDX_D))
      index_nxt = host_i.data;
    if (wr_edge && index_r == `VBS_EMU_INDEX &&
        crt_hit(a, misc_r.addr_sel, `VBS_A_DAT_B, `VBS_A_DAT_D)) begin
      emu_nxt.colour_en = host_i.data[`VBS_B_COLOUR_EN];
      emu_nxt.mono_en   = host_i.data[`VBS_B_MONO_EN];
      emu_nxt.emu_run   = host_i.data[`VBS_B_EMU_RUN];
    end
    // set wins over a clear in the same cycle
    pen_nxt = (pen_set || pen_fall) ? 1'b1 : (pen_clr ? 1'b0 : pen_r);
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      misc_r     <= `VBS_RST_MISC;
      emu_r      <= `VBS_RST_EMU;
      index_r    <= `VBS_RST_INDEX;
      pen_r      <= 1'b0;
      rd_prev_r  <= 1'b1;
      wr_prev_r  <= 1'b1;
      pen_prev_r <= 1'b1;
    end else begin
      misc_r     <= misc_nxt;
      emu_r      <= emu_nxt;
      index_r    <= index_nxt;
      pen_r      <= pen_nxt;
      rd_prev_r  <= !rd_act;
      wr_prev_r  <= stab_r[P_WR];
      pen_prev_r <= stab_r[P_PEN];
    end
  end

  // pins follow the stored misc bits
  assign clock_choice_out_0_o   = misc_r.clk_sel[0];
  assign clock_choice_out_1_o   = misc_r.clk_sel[1];
  assign own_video_select_out_o = misc_r.own_video;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  logic [7:0] rdata_r, rdata_nxt;
  logic       oe_n_r, oe_n_nxt;

  always_comb begin
    rdata_nxt = local_data_i;
    oe_n_nxt  = !rd_act;
    if (a == `VBS_A_STAT0 && mode == VBS_NATIVE)
      rdata_nxt = {local_data_i[7], stab_r[P_F1], stab_r[P_F0], stab_r[P_SW], 4'h0};
    else if (stat1_hit(a, mode, misc_r.addr_sel)) begin
      unique case (mode)
        VBS_NATIVE: rdata_nxt = {2'b11, local_data_i[5:3], stab_r[P_PSW], pen_r,
                                 local_data_i[0]};
        VBS_COLOUR: rdata_nxt = {4'hF, !stab_r[P_V], stab_r[P_PSW], pen_r,
                                 local_data_i[0]};
        VBS_MONO:   rdata_nxt = {stab_r[P_V], 3'b111, stab_r[P_MS], 2'b11,
                                 stab_r[P_H]};
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_r <= 8'h00;
      oe_n_r  <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      oe_n_r  <= oe_n_nxt;
    end
  end

  assign host_data_o      = rdata_r;
  assign host_data_oe_n_o = oe_n_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // misc write lands in the stored bits on the next edge
  a_misc_store: assert property (wr_edge && a == `VBS_A_MISC |=>
    misc_r.addr_sel == $past(host_i.data[`VBS_B_ADDR_SEL])
    && own_video_select_out_o == $past(host_i.data[`VBS_B_VIDEO]))
    else $error("misc write lost");

  // clock choice pins carry the written bits, one edge later
  a_clk_pins: assert property (wr_edge && a == `VBS_A_MISC |=>
    clock_choice_out_0_o == $past(host_i.data[`VBS_B_CLK0])
    && clock_choice_out_1_o == $past(host_i.data[`VBS_B_CLK1]))
    else $error("clock pin mismatch");

  // nothing but a misc write may move the stored bits
  a_misc_keep: assert property (!(wr_edge && a == `VBS_A_MISC) |=> $stable(misc_r))
    else $error("misc bits changed");

  // crt index follows writes at the index address of the select bit
  a_index_write: assert property (wr_edge && crt_hit(a, misc_r.addr_sel, `VBS_A_IDX_B, `VBS_A_IDX_D) |=>
    index_r == $past(host_i.data))
    else $error("index write lost");

  // emulation select bits load only behind the reserved index
  a_emu_write: assert property (wr_edge && index_r == `VBS_EMU_INDEX &&
    crt_hit(a, misc_r.addr_sel, `VBS_A_DAT_B, `VBS_A_DAT_D) |=>
    emu_r == $past(host_i.data[`VBS_B_EMU_RUN:`VBS_B_COLOUR_EN]))
    else $error("emulation select lost");

  // native status zero: controller bit 7, live pins, low nibble zero
  a_stat0_pins: assert property (rd_act && a == `VBS_A_STAT0 && mode == VBS_NATIVE |=>
    rdata_r[7] == $past(local_data_i[7]) && rdata_r[3:0] == 4'h0
    && rdata_r[6:4] == $past({stab_r[P_F1], stab_r[P_F0], stab_r[P_SW]}))
    else $error("status zero bits");

  // native status one: top bits high, latch from here, bits 0 and 3-5 from the controller
  a_stat1_native: assert property (stat1_hit(a, mode, misc_r.addr_sel) && mode == VBS_NATIVE |=>
    rdata_r[7:6] == 2'b11 && rdata_r[1] == $past(pen_r)
    && {rdata_r[5:3], rdata_r[0]} == $past({local_data_i[5:3], local_data_i[0]}))
    else $error("native status one");

  // light pen switch level wherever the layout carries it
  a_pen_switch: assert property (stat1_hit(a, mode, misc_r.addr_sel) && mode != VBS_MONO |=>
    rdata_r[2] == $past(stab_r[P_PSW]))
    else $error("pen switch bit");

  // colour status one: high nibble, inverted vertical pin, latch
  a_stat1_colour: assert property (a == `VBS_A_STAT1_D && mode == VBS_COLOUR |=>
    rdata_r[7:4] == 4'hF && rdata_r[3] == !$past(stab_r[P_V]) && rdata_r[1] == $past(pen_r)
    && rdata_r[0] == $past(local_data_i[0]))
    else $error("colour status one");

  // mono status one: fixed high bits
  a_stat1_mono: assert property (a == `VBS_A_STAT1_B && mode == VBS_MONO |=>
    rdata_r[6:4] == 3'b111 && rdata_r[2:1] == 2'b11)
    else $error("mono status one");

  // mono status one: horizontal pin, status pin, vertical sync level
  a_mono_bits: assert property (a == `VBS_A_STAT1_B && mode == VBS_MONO |=>
    rdata_r[0] == $past(stab_r[P_H]) && rdata_r[3] == $past(stab_r[P_MS])
    && rdata_r[7] == $past(stab_r[P_V]))
    else $error("mono status bits");

  // every other read comes straight from the local bus
  a_pass_through: assert property (!(a == `VBS_A_STAT0 && mode == VBS_NATIVE) &&
    !stat1_hit(a, mode, misc_r.addr_sel) |=> host_data_o == $past(local_data_i))
    else $error("pass through lost");

  // bus driven while a read is seen, released once it ends
  a_read_drive: assert property (rd_act |=> !host_data_oe_n_o [*2] or !rd_act) else $error("read not driven");
  a_bus_idle: assert property (!rd_act |=> host_data_oe_n_o) else $error("bus not released");

  // light pen latch: set by pulse or software, kept until a clear
  a_pen_set: assert property (pen_fall |=> pen_r) else $error("pen pulse not latched");
  a_pen_soft: assert property (pen_set |=> pen_r) else $error("software set lost");
  a_pen_hold: assert property (pen_r && !pen_clr |=> pen_r) else $error("pen latch lost");
  a_pen_clear: assert property (pen_clr && !pen_set && !pen_fall |=> !pen_r)
    else $error("pen latch not cleared");
  a_pen_idle: assert property (!pen_r && !pen_set && !pen_fall |=> !pen_r)
    else $error("pen latch set by itself");

  // main scenarios
  c_misc_write: cover property (wr_edge && a == `VBS_A_MISC);
  c_pen_pulse:  cover property (pen_fall ##[1:40] pen_clr);
  c_colour_rd:  cover property (mode == VBS_COLOUR && rd_edge);
  c_mono_rd:    cover property (mode == VBS_MONO && rd_edge);
  c_emu_write:  cover property (wr_edge && index_r == `VBS_EMU_INDEX);
endmodule : vbs_status_regs
`default_nettype wire

// ---- verif/vbs_host_model.sv ----
// host processor model driving the i/o strobes of the status bank
`timescale 1ns/10ps
`default_nettype none
module vbs_host_model (
  input  wire logic             clk_i,
  input  wire logic [7:0]       host_data_i,
  input  wire logic             host_data_oe_n_i,
  output vbs_pkg::vbs_host_type host_o,
  output logic                  host_rd_n_o,
  output logic                  host_wr_n_o
);
  import vbs_pkg::*;
  // ------------------------------------------------------------
  // idle bus at time zero
  // ------------------------------------------------------------
  initial begin
    host_o      = '0;
    host_rd_n_o = 1'h1;
    host_wr_n_o = 1'h1;
  end
  // one strobe held 8 edges; answer taken just after the last edge, then the
  // released bus is scrambled and kept idle so strobes stay apart
  task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
                      output logic [7:0] q, output logic oe_n);
    @(posedge clk_i);
    #1;
    host_o = '{addr: a, data: d};
    if (w) begin
      host_wr_n_o = 1'h0;
    end else begin
      host_rd_n_o = 1'h0;
    end
    repeat (8) @(posedge clk_i);
    #1;
    q    = host_data_i;
    oe_n = host_data_oe_n_i;
    host_wr_n_o = 1'h1;
    host_rd_n_o = 1'h1;
    host_o      = ~host_o;
    repeat (4) @(posedge clk_i);
  endtask : xfer
endmodule : vbs_host_model
`default_nettype wire

// ---- verif/vbs_status_regs_tb.sv ----
// self-checking bench of the video bus status register bank
`timescale 1ns/10ps
`default_nettype none
module vbs_status_regs_tb;
  import vbs_pkg::*;
  logic         clk_i, rstn_i, rd_n, wr_n, oe_n, sw, f0, f1, hor, ver, mono, pen_n, psw, ck0, ck1, vid;
  vbs_host_type host;
  logic [7:0]   hdata, ldata, idx;
  logic [31:0]  rv;
  logic [2:0]   emu, misc;
  logic         sel, latch;
  int           n_fail, total_checks;
  wire logic    colour_m = emu[2] & emu[0];
  wire logic    mono_m   = emu[2] & emu[1] & ~emu[0];

  vbs_status_regs i_vbs_status_regs (.clk_i(clk_i), .rstn_i(rstn_i), .host_i(host), .host_rd_n_i(rd_n),
    .host_wr_n_i(wr_n), .host_data_o(hdata), .host_data_oe_n_o(oe_n), .local_data_i(ldata),
    .switch_sense_i(sw), .feature_code_in_0_i(f0), .feature_code_in_1_i(f1), .horizontal_level_in_i(hor),
    .vertical_level_in_i(ver), .mono_status_in_i(mono), .pen_pulse_in_n_i(pen_n), .pen_switch_i(psw),
    .clock_choice_out_0_o(ck0), .clock_choice_out_1_o(ck1), .own_video_select_out_o(vid));
  vbs_host_model i_vbs_host_model (.clk_i(clk_i), .host_data_i(hdata), .host_data_oe_n_i(oe_n),
    .host_o(host), .host_rd_n_o(rd_n), .host_wr_n_o(wr_n));

  // ------------------------------------------------------------
  // reference model and checking tasks
  // ------------------------------------------------------------
  function automatic logic [7:0] expect_rd(input logic [9:0] a);
    if (colour_m && a == 10'h3DA) return {4'hF, ~ver, psw, latch, ldata[0]};
    if (mono_m && a == 10'h3BA) return {ver, 3'h7, mono, 2'h3, hor};
    if (!(colour_m || mono_m) && a == 10'h3C2) return {ldata[7], f1, f0, sw, 4'h0};
    if (!(colour_m || mono_m) && a == (sel ? 10'h3DA : 10'h3BA)) return {2'h3, ldata[5:3], psw, latch, ldata[0]};
    return ldata;
  endfunction : expect_rd

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic pen_upd(input logic w, input logic [9:0] a);
    logic st, cl;
    st = colour_m ? a == 10'h3DC : mono_m ? w && a == 10'h3B9 : w && a == 10'h3DC;
    cl = colour_m ? a == 10'h3DB : mono_m ? w && a == 10'h3BB : w && a == 10'h3DB;
    if (st) begin
      latch = 1'h1;
    end else if (cl) begin
      latch = 1'h0;
    end
  endtask : pen_upd

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic       o;
    i_vbs_host_model.xfer(1'h1, a, d, q, o);
    pen_upd(1'h1, a);
    if (a == 10'h3C2) begin
      sel  = d[0];
      misc = d[4:2];
    end
    if (a == (sel ? 10'h3D5 : 10'h3B5) && idx == 8'hFF) emu = d[2:0];
    if (a == (sel ? 10'h3D4 : 10'h3B4)) idx = d;
    chk("pins", {5'h0, misc}, {5'h0, vid, ck1, ck0});
  endtask : wr

  task automatic rd(input logic [9:0] a, input string name);
    logic [7:0] q, e;
    logic       o;
    @(posedge clk_i);
    #1;
    rv = $urandom();
    {sw, f0, f1, hor, ver, mono, psw} = rv[6:0];
    ldata = rv[15:8];
    e = expect_rd(a);
    i_vbs_host_model.xfer(1'h0, a, 8'h00, q, o);
    chk(name, e, q);
    chk("oe_n", 8'h00, {7'h0, o});
    pen_upd(1'h0, a);
  endtask : rd

  task automatic results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'h0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    n_fail++;
    results();
  end

  initial begin
    {n_fail, total_checks} = '0;
    {rstn_i, ldata, sw, f0, f1, hor, ver, mono, psw} = '0;
    pen_n = 1'h1;
    {sel, latch, emu, idx, misc} = '0;
    void'($urandom(32'h92BC0B98));
    repeat (16) @(posedge clk_i);
    chk("reset", 8'h01, {4'h0, vid, ck1, ck0, oe_n});
    #1;
    rstn_i = 1'h1;
    repeat (4) begin
      rv = $urandom();
      wr(10'h3C2, rv[7:0]);
      rd(10'h3C2, "stat0");
      rd(10'h3BA, "stat1_b");
      rd(10'h3DA, "stat1_d");
    end
    wr(10'h3C2, 8'h01);
    wr(10'h3DC, 8'h00);
    rd(10'h3DA, "pen_set");
    wr(10'h3DB, 8'h00);
    rd(10'h3DA, "pen_clr");
    @(posedge clk_i);
    #1;
    pen_n = 1'h0;
    repeat (6) @(posedge clk_i);
    #1;
    pen_n = 1'h1;
    latch = 1'h1;
    rd(10'h3DA, "pen_hw");
    wr(10'h3DB, 8'h00);
    wr(10'h3D4, 8'hFF);
    wr(10'h3D5, 8'h05);
    repeat (3) rd(10'h3DA, "colour");
    rd(10'h3DC, "c_set");
    rd(10'h3DA, "c_latch");
    rd(10'h3DB, "c_clr");
    rd(10'h3DA, "c_latch0");
    rd(10'h3BA, "c_stat1_b");
    wr(10'h3D5, 8'h06);
    repeat (3) rd(10'h3BA, "mono");
    rd(10'h3DA, "m_stat1_d");
    wr(10'h3B9, 8'h00);
    wr(10'h3D5, 8'h00);
    rd(10'h3DA, "m_latch");
    rd(10'h3F0, "unmapped");
    wr(10'h3C2, 8'h1C);
    @(posedge clk_i);
    #1;
    rstn_i = 1'h0;
    {sel, latch, emu, idx, misc} = '0;
    #2;
    chk("mid_reset", 8'h01, {4'h0, vid, ck1, ck0, oe_n});
    @(posedge clk_i);
    #1;
    rstn_i = 1'h1;
    rd(10'h3BA, "after_reset");
    results();
  end
endmodule : vbs_status_regs_tb
`default_nettype wire
